// ### flash_protect_map.svh
// Purpose: constants for the flash protection and identification host controller
// Assumes: core clock 10 MHz; device pins driven directly by this controller
// Notes:   every offset, command and status code and timing count lives here as a macro
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH

`define CLK_PERIOD_NS        100
// Shortest strobe low time; keeps well clear of the glitch filter width
`define GLITCH_NS            5
`define STROBE_LOW_NS        200
`define STROBE_LOW_CYC       ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS             100
`define SETUP_CYC            ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Unlock and command cycles
`define UNLOCK_ADDR1         22'h000555
`define UNLOCK_DATA1         8'hAA
`define UNLOCK_ADDR2         22'h0002AA
`define UNLOCK_DATA2         8'h55
`define ID_CMD_DATA          8'h90
`define RESET_CMD_DATA       8'hF0

// Identification address fields
`define ID_BIT6              6
`define ID_BIT1              1
`define ID_BIT0              0
`define SECTOR_LSB           16
`define SECTOR_MSB           21
`define PROTECTED_CODE       8'h01
`define UNPROTECTED_CODE     8'h00

`endif

// ### flash_protect_pkg.sv
// Purpose: types shared by the host controller files
// Assumes: nothing beyond the map header
// Notes:   one-hot state codes written out
package flash_protect_pkg;
    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_ID_HV      = 4'h1,
        OP_ID_CMD     = 4'h2,
        OP_PROGRAM    = 4'h3,
        OP_ERASE      = 4'h4,
        OP_RESET_CMD  = 4'h5
    } op_t;

    typedef enum logic [2:0] {
        ID_MAKER  = 3'h1,
        ID_PART   = 3'h2,
        ID_STATUS = 3'h4
    } id_sel_t;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_SETUP  = 7'b0000010,
        ST_STROBE = 7'b0000100,
        ST_HOLD   = 7'b0001000,
        ST_READ   = 7'b0010000,
        ST_SAMPLE = 7'b0100000,
        ST_DONE   = 7'b1000000
    } state_t;
endpackage

// ### bus_cycle_timer.sv
// Purpose: counts one bus phase of a programmable number of core clocks
// Assumes: load and count on the same clock as the caller
// Notes:   expired is a level while the count sits at zero
`timescale 1ns/1ps
module bus_cycle_timer #(
    parameter int WIDTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);
    logic [WIDTH-1:0] remain;

    initial begin
        if (WIDTH < 2) begin
            $error("bus_cycle_timer WIDTH too small");
        end
    end

    // Load wins over counting so a new phase restarts cleanly
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    // Pure count compare: the caller's load is decoded from expired, so no path may lead back
    assign expired = (remain == '0);
endmodule

// ### flash_protect_host.sv
// Purpose: host that drives a parallel flash for id reads, commands and writes
// Assumes: elevated voltages are switched by outside circuits from qualifier outputs
// Notes:   one request at a time; req taken only while ready is high
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module flash_protect_host
    import flash_protect_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int SETUP_CYCLES  = `SETUP_CYC,
    parameter int STROBE_CYCLES = `STROBE_LOW_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic                  req,
    input  wire flash_protect_pkg::op_t op,
    input  wire logic [ADDR_W-1:0]     req_addr,
    input  wire logic [7:0]            req_data,
    input  wire logic                  temp_unprotect,
    output logic                       ready,
    output logic                       done,
    output logic [7:0]                 rd_data,
    output logic                       sector_protected,
    output logic [ADDR_W-1:0]          flash_addr,
    output logic [7:0]                 data_out_bus,
    output logic                       data_oe,
    input  wire logic [7:0]            data_in_bus,
    output logic                       chip_sel_n,
    output logic                       out_en_n,
    output logic                       write_n,
    output logic                       flash_reset_n,
    output logic                       addr_bit_nine_hv,
    output logic                       out_en_hv,
    output logic                       reset_hv
);
    import flash_protect_pkg::*;

    initial begin
        if (ADDR_W != `SECTOR_MSB + 1) begin
            $error("flash_protect_host ADDR_W must cover sector bits");
        end
        if (STROBE_CYCLES < 1 || STROBE_CYCLES > 15 || SETUP_CYCLES < 1 || SETUP_CYCLES > 15) begin
            $error("flash_protect_host phase counts out of range");
        end
    end

    // Reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin input through three flops; change taken when last two agree
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic [7:0] din_s3;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1     <= 8'h00;
            din_s2     <= 8'h00;
            din_s3     <= 8'h00;
        end else begin
            din_s1 <= data_in_bus;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
        end
    end

    // Id address pattern for the three identifier kinds
    function automatic logic [ADDR_W-1:0] id_addr(input id_sel_t sel, input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] a;
        a = base & {{(ADDR_W-`SECTOR_LSB){1'b1}}, {`SECTOR_LSB{1'b0}}};
        a[`ID_BIT1] = (sel == ID_STATUS);
        a[`ID_BIT0] = (sel == ID_PART);
        a[`ID_BIT6] = 1'b0;
        return a;
    endfunction

    state_t          state;
    state_t          next_state;
    op_t             cur_op;
    logic [2:0]      cyc_idx;
    logic [2:0]      cyc_last;
    logic            timer_load;
    logic [3:0]      timer_count;
    logic            timer_expired;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0]      cyc_data;
    logic            is_read_op;
    logic [ADDR_W-1:0] latched_addr;
    logic [7:0]      latched_data;
    op_t             op_now;

    bus_cycle_timer #(.WIDTH(4)) phase_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (timer_load),
        .count    (timer_count),
        .expired  (timer_expired)
    );

    // Write cycles of each operation; unlock pair precedes every command except the reset command
    assign is_read_op = (cur_op == OP_ID_HV) || (cur_op == OP_READ_ARRAY)
                      || (cur_op == OP_ID_CMD && cyc_idx == 3'd3);
    assign cyc_last = (cur_op == OP_ID_CMD) ? 3'd3 :
                      (cur_op == OP_PROGRAM || cur_op == OP_ERASE) ? 3'd3 :
                      (cur_op == OP_RESET_CMD) ? 3'd0 : 3'd0;
    assign cyc_addr = (is_read_op) ? latched_addr :
                      (cyc_idx == 3'd0 && cur_op != OP_RESET_CMD) ? `UNLOCK_ADDR1 :
                      (cyc_idx == 3'd1) ? `UNLOCK_ADDR2 :
                      (cyc_idx == 3'd2) ? `UNLOCK_ADDR1 : latched_addr;
    assign cyc_data = (cur_op == OP_RESET_CMD) ? `RESET_CMD_DATA :
                      (cyc_idx == 3'd0) ? `UNLOCK_DATA1 :
                      (cyc_idx == 3'd1) ? `UNLOCK_DATA2 :
                      (cyc_idx == 3'd2 && cur_op == OP_ID_CMD) ? `ID_CMD_DATA :
                      latched_data;
    assign timer_count = (next_state == ST_SETUP) ? SETUP_CYCLES[3:0] : STROBE_CYCLES[3:0];
    assign timer_load  = (next_state != state) && (next_state == ST_SETUP || next_state == ST_STROBE
                       || next_state == ST_READ || next_state == ST_HOLD);
    assign ready = (state == ST_IDLE);
    // Operation in force this cycle; cur_op lags one edge behind the take
    assign op_now = (state == ST_IDLE) ? op : cur_op;

    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:   if (req) next_state = ST_SETUP;
            ST_SETUP:  if (timer_expired) next_state = is_read_op ? ST_READ : ST_STROBE;
            ST_STROBE: if (timer_expired) next_state = ST_HOLD;
            ST_HOLD:   if (timer_expired) next_state = (cyc_idx == cyc_last) ? ST_DONE : ST_SETUP;
            ST_READ:   if (timer_expired) next_state = ST_SAMPLE;
            ST_SAMPLE: if (din_s2 == din_s3) next_state = ST_DONE;
            ST_DONE:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            cur_op       <= OP_READ_ARRAY;
            cyc_idx      <= 3'd0;
            latched_addr <= '0;
            latched_data <= 8'h00;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && req) begin
                cur_op       <= op;
                cyc_idx      <= 3'd0;
                latched_addr <= (op == OP_ID_HV) ? id_addr(id_sel_t'(req_data[2:0]), req_addr) : req_addr;
                latched_data <= req_data;
            end else if (state == ST_HOLD && timer_expired && cyc_idx != cyc_last) begin
                cyc_idx <= cyc_idx + 3'd1;
            end
        end
    end

    // Read results; status byte equal to 01 means the sector block is protected
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data          <= 8'h00;
            sector_protected <= 1'b0;
        end else if (state == ST_SAMPLE && next_state == ST_DONE) begin
            rd_data          <= din_s3;                                   // Settled: second and third agree
            sector_protected <= (din_s3 == `PROTECTED_CODE);
        end
    end

    // Pin drive; write strobes long and clean, never overlapping output enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_addr       <= '0;
            data_out_bus     <= 8'h00;
            data_oe          <= 1'b0;
            chip_sel_n       <= 1'b1;
            out_en_n         <= 1'b1;
            write_n          <= 1'b1;
            addr_bit_nine_hv <= 1'b0;
        end else begin
            flash_addr       <= cyc_addr;
            data_out_bus     <= cyc_data;
            data_oe          <= (next_state == ST_SETUP || next_state == ST_STROBE || next_state == ST_HOLD)
                             && !is_read_op;
            chip_sel_n       <= !(next_state == ST_STROBE || next_state == ST_READ || next_state == ST_SAMPLE);
            write_n          <= !(next_state == ST_STROBE);
            out_en_n         <= !(next_state == ST_READ || next_state == ST_SAMPLE);
            addr_bit_nine_hv <= (op_now == OP_ID_HV) && (next_state != ST_IDLE);
        end
    end

    // Reset pin follows core reset; elevated reset only on request
    assign flash_reset_n = rst_n;
    assign reset_hv      = temp_unprotect && rst_n;
    assign out_en_hv     = 1'b0;
    assign done          = (state == ST_DONE);

    // Assertions
    write_excl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !write_n |-> (!chip_sel_n && out_en_n)) else $error("write without proper strobes");
    write_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(write_n) |-> !write_n [*2]) else $error("write pulse too short");
    hv_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (addr_bit_nine_hv && !out_en_n) |-> (!chip_sel_n && write_n)) else $error("id read pins wrong");
    id_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (addr_bit_nine_hv && !out_en_n) |-> !flash_addr[`ID_BIT6]) else $error("id address bit six high");
    unlock_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($fell(write_n) && cyc_idx == 3'd0 && cur_op == OP_PROGRAM) |-> flash_addr == `UNLOCK_ADDR1)
        else $error("program without unlock");
    done_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done |=> !done && ready) else $error("done not one pulse");
    alt_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !out_en_hv) else $error("alternate voltage driven");
    status_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_SAMPLE && next_state == ST_DONE && din_s3 == 8'h00) |=> !sector_protected)
        else $error("status decode wrong");
    bus_turn_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !out_en_n |-> !data_oe) else $error("host drives data during read");
    cov_hv: cover property (@(posedge core_clk) disable iff (!rst_n) done && cur_op == OP_ID_HV);
    cov_cmd: cover property (@(posedge core_clk) disable iff (!rst_n) done && cur_op == OP_ID_CMD);
    cov_prog: cover property (@(posedge core_clk) disable iff (!rst_n) done && cur_op == OP_PROGRAM);
endmodule

// ### flash_device_model.sv
// Purpose: behavioural flash device on the far side of the host controller
// Assumes: elevated voltages arrive as qualifier levels; supply lockout set by a task
// Notes:   array kept sparse by sector and low nibble; tasks set protection
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module flash_device_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h3E  // Arbitrary value
) (
    input  wire logic [21:0] flash_addr,
    input  wire logic [7:0]  host_data,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_n,
    input  wire logic        flash_reset_n,
    input  wire logic        addr_bit_nine_hv, // Level qualifier
    input  wire logic        reset_hv,         // Level qualifier
    output logic [7:0]       data_to_host
);
    logic [7:0]  mem [0:1023];
    logic [17:0] prot = '0;    // Delivered unprotected
    logic [1:0]  seq = 2'h0;   // Starts in array read
    logic        id_mode = 1'b0;
    logic        pu_blk = 1'b1;
    logic        supply_low = 1'b0;
    logic [21:0] lat_addr = '0;
    logic [7:0]  rd_val;
    logic [7:0]  last_q = 8'h00;
    realtime     t_fall = 0.0;
    wire         wr_strobe_n = chip_sel_n | write_n | ~out_en_n;
    wire         reading = flash_reset_n & ~chip_sel_n & ~out_en_n & write_n;

    // Sector to block number
    function automatic int blk(input logic [5:0] s);
        if (s == 6'h00) return 0;
        if (s <= 6'h03) return 1;
        if (s == 6'h3F) return 17;
        if (s >= 6'h3C) return 16;
        return int'(s) / 4 + 1;
    endfunction

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
    end

    task automatic protect_sector(input logic [5:0] s);
        prot[blk(s)] = 1'b1;
    endtask

    // Supply below lockout: writes ignored and the device resets
    task automatic set_supply_low(input logic low);
        supply_low = low;
        if (low) begin
            seq = 2'h0;
            id_mode = 1'b0;
        end
    endtask

    // Everything protected before clearing
    task automatic unprotect_all();
        prot = '1;
        prot = '0;
    endtask

    // Refused on a protected block unless reset pin is elevated
    task automatic store(input logic [21:0] a, input logic [7:0] d);
        if (!prot[blk(a[21:16])] || reset_hv)
            mem[{a[21:16], a[3:0]}] = d;
    endtask

    // Unlock decoder; a wrong cycle drops back to array read
    task automatic take_write(input logic [7:0] d);
        if (d == `RESET_CMD_DATA) begin
            seq = 2'h0;
            id_mode = 1'b0;
        end else begin
            case (seq)
                2'h0: seq = (lat_addr == `UNLOCK_ADDR1 && d == `UNLOCK_DATA1) ? 2'h1 : 2'h0;
                2'h1: seq = (lat_addr == `UNLOCK_ADDR2 && d == `UNLOCK_DATA2) ? 2'h2 : 2'h0;
                2'h2: begin
                    if (lat_addr == `UNLOCK_ADDR1 && d == `ID_CMD_DATA)
                        id_mode = 1'b1;
                    else if (lat_addr != `UNLOCK_ADDR1)
                        store(lat_addr, d);
                    seq = (lat_addr == `UNLOCK_ADDR1 && d != `ID_CMD_DATA) ? 2'h3 : 2'h0;
                end
                default: begin
                    store(lat_addr, d);
                    seq = 2'h0;
                end
            endcase
        end
    endtask

    // Address at the later fall; a fall at time zero is power-up
    always @(negedge wr_strobe_n) begin
        lat_addr = flash_addr;
        t_fall = $realtime;
        if ($realtime > 0) pu_blk = 1'b0;
    end

    // Data at the first rise; short pulses are noise
    always @(posedge wr_strobe_n) begin
        if (flash_reset_n && !pu_blk && !supply_low && ($realtime - t_fall >= 5.0))
            take_write(host_data);
    end

    // Reset pin low abandons any sequence
    always @(negedge flash_reset_n) begin
        seq = 2'h0;
        id_mode = 1'b0;
    end

    // Identifier select by address bits
    always_comb begin
        if (addr_bit_nine_hv || id_mode) begin
            if (flash_addr[`ID_BIT0]) rd_val = PART_CODE;
            else if (flash_addr[`ID_BIT1]) rd_val = prot[blk(flash_addr[21:16])] ? `PROTECTED_CODE : `UNPROTECTED_CODE;
            else rd_val = MAKER_CODE;
        end else
            rd_val = mem[{flash_addr[21:16], flash_addr[3:0]}];
    end

    // Released bus shows the inverse of the last byte: no pull on these pins
    assign data_to_host = reading ? rd_val : ~last_q;
    always @(rd_val or reading) begin
        if (reading) last_q = rd_val;
    end
endmodule

// ### test_flash_protect_host.sv
// Purpose: self-checking bench for the flash protection host controller
// Assumes: default setup and strobe counts; device model on the pins
// Notes:   one task per scenario; protection is preset through model tasks
`timescale 1ns/1ps
module test_flash_protect_host;
    import flash_protect_pkg::*;
    localparam logic [7:0] MAKER_CODE = 8'h5C; // Arbitrary value
    localparam logic [7:0] PART_CODE  = 8'h3E; // Arbitrary value
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req = 1'b0;
    op_t  op = OP_READ_ARRAY;
    logic [21:0] req_addr = '0;
    logic [7:0]  req_data = '0;
    logic temp_unprotect = 1'b0;
    logic ready, done, sector_protected, data_oe, chip_sel_n, out_en_n, write_n;
    logic flash_reset_n, addr_bit_nine_hv, out_en_hv, reset_hv;
    logic [7:0]  rd_data, data_out_bus, data_in_bus;
    logic [21:0] flash_addr;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    flash_protect_host flash_protect_host_inst (.core_clk(core_clk), .reset_n(reset_n), .req(req), .op(op),
        .req_addr(req_addr), .req_data(req_data), .temp_unprotect(temp_unprotect), .ready(ready), .done(done),
        .rd_data(rd_data), .sector_protected(sector_protected), .flash_addr(flash_addr),
        .data_out_bus(data_out_bus), .data_oe(data_oe), .data_in_bus(data_in_bus), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_n(write_n), .flash_reset_n(flash_reset_n),
        .addr_bit_nine_hv(addr_bit_nine_hv), .out_en_hv(out_en_hv), .reset_hv(reset_hv));

    flash_device_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) flash_device_model_inst (
        .flash_addr(flash_addr), .host_data(data_out_bus), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_n(write_n), .flash_reset_n(flash_reset_n), .addr_bit_nine_hv(addr_bit_nine_hv),
        .reset_hv(reset_hv), .data_to_host(data_in_bus));

    always #50 core_clk = ~core_clk;

    task automatic close_out();
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One request, then a bounded wait for done; rd_data is read a cycle later
    task automatic do_op(input op_t o, input logic [21:0] a, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        req <= 1'b1;
        op <= o;
        req_addr <= a;
        req_data <= d;
        @(posedge core_clk);
        req <= 1'b0;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (done !== 1'b1 && i < 400);
        check(done, 1'b1);
        @(negedge core_clk);
    endtask

    task automatic t_ident();
        do_op(OP_ID_HV, 22'h000000, 8'h01);
        check(rd_data, MAKER_CODE);
        do_op(OP_ID_HV, 22'h000000, 8'h02);
        check(rd_data, PART_CODE);
        do_op(OP_ID_CMD, 22'h000000, 8'h00);
        check(rd_data, MAKER_CODE);
        do_op(OP_ID_CMD, 22'h000001, 8'h00);
        check(rd_data, PART_CODE);
        do_op(OP_RESET_CMD, 22'h000000, 8'h00);
        do_op(OP_READ_ARRAY, 22'h000100, 8'h00);
        check(rd_data, 8'hFF);
    endtask

    // Block edges: sectors 1-3 and 60-62 grouped, 0 and 63 alone
    task automatic t_status();
        logic [5:0] secs [8] = '{6'd0, 6'd1, 6'd3, 6'd4, 6'd59, 6'd60, 6'd62, 6'd63};
        logic       prot [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        do_op(OP_ID_HV, 22'h280000, 8'h04);
        check(rd_data, 8'h00);
        flash_device_model_inst.protect_sector(6'd2);
        flash_device_model_inst.protect_sector(6'd61);
        for (int k = 0; k < 8; k++) begin
            do_op(OP_ID_HV, {secs[k], 16'h0000}, 8'h04);
            check(rd_data, {7'h00, prot[k]});
            check({7'h00, sector_protected}, {7'h00, prot[k]});
        end
        do_op(OP_ID_CMD, 22'h3D0002, 8'h00);
        check(rd_data, 8'h01);
        do_op(OP_RESET_CMD, 22'h000000, 8'h00);
    endtask

    task automatic t_program();
        do_op(OP_PROGRAM, 22'h031234, 8'h3C);
        do_op(OP_READ_ARRAY, 22'h031234, 8'h00);
        check(rd_data, 8'hFF);
        do_op(OP_PROGRAM, 22'h041234, 8'h3C);
        do_op(OP_READ_ARRAY, 22'h041234, 8'h00);
        check(rd_data, 8'h3C);
        @(posedge core_clk);
        temp_unprotect <= 1'b1;
        @(negedge core_clk);
        check({7'h00, reset_hv}, 8'h01);
        do_op(OP_PROGRAM, 22'h031234, 8'hA5);
        do_op(OP_READ_ARRAY, 22'h031234, 8'h00);
        check(rd_data, 8'hA5);
        @(posedge core_clk);
        temp_unprotect <= 1'b0;
        do_op(OP_PROGRAM, 22'h030040, 8'h5A);
        do_op(OP_READ_ARRAY, 22'h030040, 8'h00);
        check(rd_data, 8'hFF);
        do_op(OP_ERASE, 22'h031234, 8'hFF);
        do_op(OP_READ_ARRAY, 22'h031234, 8'h00);
        check(rd_data, 8'hA5);
        flash_device_model_inst.unprotect_all();
        do_op(OP_PROGRAM, 22'h010010, 8'h66);
        do_op(OP_READ_ARRAY, 22'h010010, 8'h00);
        check(rd_data, 8'h66);
    endtask

    // Writes during supply lockout are dropped, taken again once supply is back
    task automatic t_lockout();
        flash_device_model_inst.set_supply_low(1'b1);
        do_op(OP_PROGRAM, 22'h060008, 8'h42);
        flash_device_model_inst.set_supply_low(1'b0);
        do_op(OP_READ_ARRAY, 22'h060008, 8'h00);
        check(rd_data, 8'hFF);
        do_op(OP_PROGRAM, 22'h060008, 8'h42);
        do_op(OP_READ_ARRAY, 22'h060008, 8'h00);
        check(rd_data, 8'h42);
    endtask

    // Reset in mid-program: strobes released, sequence lost
    task automatic t_abort();
        @(posedge core_clk);
        req <= 1'b1;
        op <= OP_PROGRAM;
        req_addr <= 22'h050004;
        req_data <= 8'h77;
        @(posedge core_clk);
        req <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b0;
        @(negedge core_clk);
        check({2'h0, ready, data_oe, flash_reset_n, chip_sel_n, write_n, out_en_n}, 8'h27);
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        do_op(OP_READ_ARRAY, 22'h050004, 8'h00);
        check(rd_data, 8'hFF);
    endtask

    // Hang guard, well above the several hundred cycles the scenarios need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_ident();
        t_status();
        t_program();
        t_lockout();
        t_abort();
        check({7'h00, out_en_hv}, 8'h00);
        close_out();
    end
endmodule
